// file: design/sbfc_serial_config.v
// Purpose: baud generator, frame format and routing of an async serial port
// Assumes: one 10 MHz clock, register port on the same clock
// Notes:   second control register bits and the flag detectors live outside
//
// How it works
// [RULE_01] High byte buffered, applied on low write
// [RULE_02] Generator idle until receiver or transmitter on
// [RULE_03] Zero divisor stops the generator
// [RULE_04] Bit rate is clock over sixteen divisor
// [RULE_05] Bit 7 enables break detect interrupt
// [RULE_06] Bit 6 enables receive edge interrupt
// [RULE_07] Loop select routes transmitter into receiver
// [RULE_08] Receiver source only matters in loop
// [RULE_09] Loop, source zero: internal loop back
// [RULE_10] Loop, source one: single wire on pin
// [RULE_11] Eight bit frame, start, data, stop
// [RULE_12] Nine bit frame adds ninth data bit
// [RULE_13] Idle type picks where idle counting starts
// [RULE_14] Parity replaces most significant data bit
// [RULE_15] Parity kind: zero even, one odd
// [RULE_16] Host sees registers at its base addresses
// [RULE_17] Direction control steers the single line
// [RULE_18] Receive pin released when off or looped
// [RULE_19] Down counter gives sixteen times strobe
`timescale 1ns/1ps
`include "sbfc_defines.vh"

module sbfc_serial_config (
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // Controls held outside
  input  wire       transmitter_on,
  input  wire       receiver_on,
  input  wire       single_line_direction,
  input  wire       break_detect_flag,
  input  wire       rx_edge_flag,
  output reg        irq_request,
  // Transmit words
  input  wire [8:0] tx_data,
  input  wire       tx_valid,
  output wire       tx_ready,
  // Receive words
  output reg  [8:0] rx_data,
  output reg        rx_parity_err,
  output reg        rx_frame_err,
  output wire       rx_valid,
  input  wire       rx_ready,
  output reg        rx_overrun,
  output reg        idle_detected,
  // Serial pins
  output wire       txd_out,
  output reg        txd_oe,
  input  wire       txd_in,
  input  wire       rxd_in,
  output reg        rxd_pin_used,
  // Status
  output reg        baud_tick,
  output reg        baud_running
);

  localparam RX_IDLE  = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA  = 2'd2;
  reg  [4:0]  hi_buf_q, hi_work_q;
  reg  [7:0]  lo_q, ctrl_q, idle_q;
  reg         brk_en_q, edge_en_q, armed_q, busy_q, idle_done_q;
  reg  [12:0] cnt_q;
  reg  [10:0] tsh_q, spare_q;
  reg  [3:0]  tleft_q, tsub_q, rsub_q, rcnt_q;
  reg  [1:0]  rst_q, fill_q, pin_lvl_q;
  reg  [9:0]  rsh_q;
  reg  [2:0]  sync_q [0:1];
  wire [12:0] divisor_value = {hi_work_q, lo_q};
  wire        loop_select = ctrl_q[`SBFC_BIT_LOOP];
  wire        receiver_source_select = ctrl_q[`SBFC_BIT_RECEIVER_SOURCE_SELECT];
  wire        char9 = ctrl_q[`SBFC_BIT_CHAR9];
  wire        idle_type_select = ctrl_q[`SBFC_BIT_IDLE_TYPE];
  wire        parity_on = ctrl_q[`SBFC_BIT_PARITY_ON];
  wire        parity_kind = ctrl_q[`SBFC_BIT_PARITY_KIND];
  wire        single_wire = loop_select & receiver_source_select;

  // Pin inputs: three flops, level moves once the last two agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      wire pin_raw = (gi == 0) ? rxd_in : txd_in;
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync_q[gi]    <= 3'h7;
          pin_lvl_q[gi] <= 1'b1;
        end else begin
          sync_q[gi] <= {sync_q[gi][1:0], pin_raw};
          if (sync_q[gi][1] == sync_q[gi][2])
            pin_lvl_q[gi] <= sync_q[gi][2];
        end
      end
    end
  endgenerate

  // Register port; rows 0x40..0x42 as seen from the host base
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_buf_q  <= 5'h00;
      hi_work_q <= 5'h00;
      brk_en_q  <= 1'b0;
      edge_en_q <= 1'b0;
      lo_q      <= `SBFC_RST_BAUD_LO;
      ctrl_q    <= `SBFC_RST_CTRL_ONE;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `SBFC_OFS_BAUD_HI: begin
            // [RULE_01] stage high half only
            hi_buf_q  <= reg_wdata[4:0];
            brk_en_q  <= reg_wdata[`SBFC_BIT_BRK_IRQ_EN];
            edge_en_q <= reg_wdata[`SBFC_BIT_EDGE_IRQ_EN];
          end
          `SBFC_OFS_BAUD_LO: begin
            // [RULE_01] both halves together
            lo_q      <= reg_wdata;
            hi_work_q <= hi_buf_q;
          end
          `SBFC_OFS_CTRL_ONE: ctrl_q <= reg_wdata & 8'hb7;
          default: ctrl_q <= ctrl_q;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `SBFC_OFS_BAUD_HI:  reg_rdata <= {brk_en_q, edge_en_q, 1'b0, hi_work_q};
          `SBFC_OFS_BAUD_LO:  reg_rdata <= lo_q;
          `SBFC_OFS_CTRL_ONE: reg_rdata <= ctrl_q;
          default:            reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // [RULE_02] [RULE_03] armed by first enable, stopped at zero
  wire run  = armed_q & (divisor_value != 13'h0000);
  // [RULE_19] terminal count strobe
  wire tick = run & (cnt_q == 13'h0001);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_q      <= 1'b0;
      cnt_q        <= 13'h0000;
      baud_tick    <= 1'b0;
      baud_running <= 1'b0;
    end else begin
      if (receiver_on | transmitter_on)
        armed_q <= 1'b1;
      // [RULE_04] period of divisor cycles; zero count reloads, no wrap
      if (!run || tick || (cnt_q == 13'h0000))
        cnt_q <= divisor_value;
      else
        cnt_q <= cnt_q - 13'h0001;
      baud_tick    <= tick;
      baud_running <= run;
    end
  end

  // [RULE_14] [RULE_15] parity into the top data bit
  wire       par8 = (^tx_data[6:0]) ^ parity_kind;
  wire       par9 = (^tx_data[7:0]) ^ parity_kind;
  wire [8:0] tword = !parity_on ? tx_data :
                     char9 ? {par9, tx_data[7:0]} : {1'b0, par8, tx_data[6:0]};
  assign tx_ready = transmitter_on & run & ~busy_q;
  assign txd_out  = tsh_q[0];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q  <= 1'b0;
      tsh_q   <= 11'h7ff;
      tleft_q <= 4'h0;
      tsub_q  <= 4'h0;
      txd_oe  <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        busy_q <= 1'b1;
        tsub_q <= 4'h0;
        // [RULE_11] [RULE_12] start, data lsb first, stop
        if (char9) begin
          tsh_q   <= {1'b1, tword, 1'b0};
          tleft_q <= 4'hb;
        end else begin
          tsh_q   <= {2'h3, tword[7:0], 1'b0};
          tleft_q <= 4'ha;
        end
      end else if (busy_q && tick) begin
        tsub_q <= tsub_q + 4'h1;
        if (tsub_q == `SBFC_OS_LAST) begin
          tsh_q   <= {1'b1, tsh_q[10:1]};
          tleft_q <= tleft_q - 4'h1;
          if (tleft_q == 4'h1)
            busy_q <= 1'b0;
        end
      end
      // [RULE_17] single line driven only toward the wire
      txd_oe <= (transmitter_on | busy_q) & (~single_wire | single_line_direction);
    end
  end

  // [RULE_07] [RULE_08] [RULE_09] [RULE_10] receiver input routing
  wire rx_line = !loop_select ? pin_lvl_q[0] :
                 receiver_source_select ? pin_lvl_q[1] : tsh_q[0];
  wire [9:0] rfin  = {rx_line, rsh_q[9:1]};
  wire [8:0] rword = char9 ? rfin[8:0] : {1'b0, rfin[8:1]};
  wire [3:0] rbits = char9 ? 4'ha : 4'h9;
  wire       rdone = (rst_q == RX_DATA) & tick & (rsub_q == `SBFC_OS_LAST) &
                     (rcnt_q == rbits - 4'h1);
  // [RULE_15] count of ones including the parity bit
  wire       rperr = parity_on & ((^rword) != parity_kind);
  wire       pop   = rx_valid & rx_ready;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q  <= RX_IDLE;
      rsub_q <= 4'h0;
      rcnt_q <= 4'h0;
      rsh_q  <= 10'h000;
    end else if (!receiver_on || !run) begin
      rst_q <= RX_IDLE;
    end else if (tick) begin
      case (rst_q)
        RX_IDLE: begin
          rsub_q <= 4'h0;
          rcnt_q <= 4'h0;
          if (!rx_line)
            rst_q <= RX_START;
        end
        RX_START: begin
          rsub_q <= rsub_q + 4'h1;
          if (rsub_q == `SBFC_OS_MID) begin
            rsub_q <= 4'h0;
            rst_q  <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          rsub_q <= rsub_q + 4'h1;
          if (rsub_q == `SBFC_OS_LAST) begin
            rsh_q  <= rfin;
            rcnt_q <= rcnt_q + 4'h1;
            if (rdone)
              rst_q <= RX_IDLE;
          end
        end
        default: rst_q <= RX_IDLE;
      endcase
    end
  end

  // Two-entry receive buffer; head feeds the outputs directly
  assign rx_valid = (fill_q != 2'd0);
  wire [10:0] rentry = {rfin[9] == 1'b0, rperr, rword};
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fill_q        <= 2'd0;
      spare_q       <= 11'h000;
      rx_data       <= 9'h000;
      rx_parity_err <= 1'b0;
      rx_frame_err  <= 1'b0;
      rx_overrun    <= 1'b0;
    end else begin
      rx_overrun <= rdone & (fill_q == 2'd2) & ~pop;
      case (fill_q)
        2'd0: if (rdone) begin
          {rx_frame_err, rx_parity_err, rx_data} <= rentry;
          fill_q <= 2'd1;
        end
        2'd1: begin
          if (rdone && pop)
            {rx_frame_err, rx_parity_err, rx_data} <= rentry;
          else if (rdone) begin
            spare_q <= rentry;
            fill_q  <= 2'd2;
          end else if (pop)
            fill_q <= 2'd0;
        end
        2'd2: if (pop) begin
          {rx_frame_err, rx_parity_err, rx_data} <= spare_q;
          if (rdone)
            spare_q <= rentry;
          else
            fill_q <= 2'd1;
        end
        default: fill_q <= 2'd0;
      endcase
    end
  end

  // [RULE_13] idle count from after start or after stop
  wire [7:0] idle_need = char9 ? `SBFC_IDLE_TICKS_9 : `SBFC_IDLE_TICKS_8;
  wire       idle_hold = ~rx_line | (idle_type_select & (rst_q != RX_IDLE));
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_q        <= 8'h00;
      idle_done_q   <= 1'b0;
      idle_detected <= 1'b0;
    end else begin
      idle_detected <= 1'b0;
      if (!receiver_on) begin
        idle_q      <= 8'h00;
        idle_done_q <= 1'b0;
      end else if (tick) begin
        if (idle_hold) begin
          idle_q      <= 8'h00;
          // Re-arm only after a low, so one idle line reports once
          idle_done_q <= idle_done_q & rx_line;
        end else if (!idle_done_q) begin
          idle_q <= idle_q + 8'h01;
          if (idle_q + 8'h01 == idle_need) begin
            idle_done_q   <= 1'b1;
            idle_detected <= 1'b1;
          end
        end
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_request  <= 1'b0;
      rxd_pin_used <= 1'b0;
    end else begin
      // [RULE_05] [RULE_06] enabled flags request interrupt
      irq_request  <= (brk_en_q & break_detect_flag) | (edge_en_q & rx_edge_flag);
      // [RULE_18] pin released when off or looped
      rxd_pin_used <= receiver_on & ~loop_select;
    end
  end

endmodule

// file: design/sbfc_defines.vh
// Purpose: constants for the serial port baud and frame configuration block
// Assumes: included by its bare name from the design file
// Notes:   offsets are register port addresses
`ifndef SBFC_DEFINES_VH
`define SBFC_DEFINES_VH

// Register offsets
`define SBFC_OFS_BAUD_HI      8'h40
`define SBFC_OFS_BAUD_LO      8'h41
`define SBFC_OFS_CTRL_ONE     8'h42

// Field positions, high baud register
`define SBFC_BIT_BRK_IRQ_EN   7
`define SBFC_BIT_EDGE_IRQ_EN  6

// Field positions, control register one
`define SBFC_BIT_LOOP         7
`define SBFC_BIT_RECEIVER_SOURCE_SELECT         5
`define SBFC_BIT_CHAR9        4
`define SBFC_BIT_IDLE_TYPE    2
`define SBFC_BIT_PARITY_ON    1
`define SBFC_BIT_PARITY_KIND  0

// Reset values
`define SBFC_RST_BAUD_HI      8'h00
`define SBFC_RST_BAUD_LO      8'h04
`define SBFC_RST_CTRL_ONE     8'h00

// Timing counts, in oversampling ticks
`define SBFC_OS_LAST          4'hf
`define SBFC_OS_MID           4'h7
`define SBFC_IDLE_TICKS_8     8'ha0
`define SBFC_IDLE_TICKS_9     8'hb0

`endif

// file: verif/sbfc_line_model.sv
// Purpose: far side of the serial pins, a bus transceiver
// Assumes: line pulled up, any party may pull it low
// Notes:   remote_low stands for a remote node holding the line
`timescale 1ns/1ps
module sbfc_line_model (
  // Device pins
  input  wire txd_out,
  input  wire txd_oe,
  output wire txd_in,
  output wire rxd_in,
  // Remote node
  input  wire remote_low
);
  wire bus_level = ~((txd_oe & ~txd_out) | remote_low);
  assign txd_in = bus_level;
  assign rxd_in = bus_level;
endmodule

// file: verif/sbfc_serial_config_checker.sv
// Purpose: port checks for the serial config block
// Assumes: registers mirrored from writes seen at the port
// Notes:   tick spacing judged only with a steady divisor
`timescale 1ns/1ps
module sbfc_serial_config_checker (
  // Clock, reset and register port
  input wire       clk, reset_n, reg_wr,
  input wire [7:0] reg_addr, reg_wdata,
  // Controls and flags
  input wire       transmitter_on, receiver_on, single_line_direction,
  input wire       break_detect_flag, rx_edge_flag, irq_request,
  // Data and pins
  input wire       tx_valid, tx_ready, rx_valid, rx_ready, rx_overrun,
  input wire [8:0] rx_data,
  input wire       txd_out, txd_oe, rxd_pin_used, baud_tick, baud_running
);
  logic [1:0]  en_q, chg_q;
  logic [4:0]  hb_q;
  logic [12:0] div_q, gap_q;
  logic [7:0]  c1_q;
  logic        arm_q, seen_q;
  wire         wr_hi = reg_wr && reg_addr == 8'h40;
  wire         wr_lo = reg_wr && reg_addr == 8'h41;
  wire         irq_w = (en_q[1] & break_detect_flag) | (en_q[0] & rx_edge_flag);
  wire         pin_w = receiver_on & ~c1_q[7];
  wire         oe_w  = transmitter_on & (~(c1_q[7] & c1_q[5]) | single_line_direction);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q   <= 2'h0;
      chg_q  <= 2'h0;
      hb_q   <= 5'h0;
      div_q  <= 13'h4;
      gap_q  <= 13'h0;
      c1_q   <= 8'h0;
      arm_q  <= 1'h0;
      seen_q <= 1'h0;
    end else begin
      if (wr_hi) en_q <= reg_wdata[7:6];
      if (wr_hi) hb_q <= reg_wdata[4:0];
      if (wr_lo) div_q <= {hb_q, reg_wdata};
      if (reg_wr && reg_addr == 8'h42) c1_q <= reg_wdata;
      if (transmitter_on | receiver_on) arm_q <= 1'h1;
      // Old divisor may still finish the running count
      if (wr_lo) chg_q <= 2'h2;
      else if (baud_tick && chg_q != 2'h0) chg_q <= chg_q - 2'h1;
      seen_q <= baud_tick ? baud_running : seen_q & baud_running;
      gap_q  <= baud_tick ? 13'h1 : gap_q + 13'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_irq; irq_request == $past(irq_w); endproperty
  a_irq: assert property (p_irq) else $error("irq not from enabled flags");
  property p_pin; rxd_pin_used == $past(pin_w); endproperty
  a_pin: assert property (p_pin) else $error("receive pin use wrong");
  property p_oe; $past(oe_w) |-> txd_oe; endproperty
  a_oe: assert property (p_oe) else $error("transmit pin not driven");
  property p_arm; !arm_q |-> !baud_running; endproperty
  a_arm: assert property (p_arm) else $error("generator ran before enable");
  property p_zero; baud_running |-> $past(div_q) != 13'h0; endproperty
  a_zero: assert property (p_zero) else $error("generator ran at zero divisor");
  property p_gap; baud_tick && seen_q && chg_q == 2'h0 |-> gap_q == div_q; endproperty
  a_gap: assert property (p_gap) else $error("tick spacing not divisor");
  property p_start; tx_valid && tx_ready |=> !txd_out && !tx_ready; endproperty
  a_start: assert property (p_start) else $error("no start bit after take");
  property p_rx8; rx_valid && !c1_q[4] |-> !rx_data[8]; endproperty
  a_rx8: assert property (p_rx8) else $error("ninth bit set in 8 bit mode");

  c_take: cover property (tx_valid && tx_ready);
  c_pop: cover property (rx_valid && rx_ready);
  c_ovr: cover property (rx_overrun);
  c_irq: cover property (irq_request);
endmodule

bind sbfc_serial_config sbfc_serial_config_checker sbfc_serial_config_checker_i (
  .clk, .reset_n, .reg_wr, .reg_addr, .reg_wdata, .transmitter_on, .receiver_on,
  .single_line_direction, .break_detect_flag, .rx_edge_flag, .irq_request, .tx_valid,
  .tx_ready, .rx_valid, .rx_ready, .rx_overrun, .rx_data, .txd_out, .txd_oe,
  .rxd_pin_used, .baud_tick, .baud_running
);

// file: verif/sbfc_serial_config_tb.sv
// Purpose: self-checking bench for the serial config block
// Assumes: line model echoes the bus like a transceiver
// Notes:   divisor 1 gives 16 clocks a bit
`timescale 1ns/1ps
module sbfc_serial_config_tb;
  logic       clk = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0;
  logic       transmitter_on = 1'h0, receiver_on = 1'h0, single_line_direction = 1'h1;
  logic       break_detect_flag = 1'h0, rx_edge_flag = 1'h0, tx_valid = 1'h0;
  logic       rx_ready = 1'h0, remote_low = 1'h0, ovr_seen = 1'h0;
  logic [8:0] tx_data = 9'h0;
  wire  [7:0] reg_rdata;
  wire  [8:0] rx_data;
  wire        irq_request, tx_ready, rx_parity_err, rx_frame_err, rx_valid, rx_overrun;
  wire        txd_out, txd_oe, txd_in, rxd_in, rxd_pin_used, baud_tick, baud_running;
  wire        idle_detected;
  int         fail_count = 0, total_checks = 0, idle_cnt = 0;

  sbfc_serial_config sbfc_serial_config_i (
    .clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .transmitter_on, .receiver_on, .single_line_direction, .break_detect_flag,
    .rx_edge_flag, .irq_request, .tx_data, .tx_valid, .tx_ready, .rx_data,
    .rx_parity_err, .rx_frame_err, .rx_valid, .rx_ready, .rx_overrun,
    .idle_detected, .txd_out, .txd_oe, .txd_in, .rxd_in, .rxd_pin_used,
    .baud_tick, .baud_running
  );
  sbfc_line_model sbfc_line_model_i (.txd_out, .txd_oe, .txd_in, .rxd_in, .remote_low);

  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (rx_overrun) ovr_seen <= 1'h1;
    if (idle_detected) idle_cnt <= idle_cnt + 1;
  end

  task automatic chk(input string nm, input logic [8:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Select 0 tx_ready, 1 rx_valid, 2 baud_tick; nets cannot go by reference
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while ((sel == 0 ? tx_ready : sel == 1 ? rx_valid : baud_tick) !== 1'h1) begin
      @(negedge clk);
      n++;
      if (n > 4000) begin
        fail_count++;
        end_sim();
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge clk);
    reg_wr = 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge clk);
    reg_rd = 1'h0;
    chk("reg_rdata", {1'h0, exp}, {1'h0, reg_rdata});
  endtask

  // Parity takes the top data bit of the character
  function automatic logic [8:0] frame(input logic [7:0] c, input logic [8:0] d);
    logic [8:0] w;
    w = c[4] ? d : {1'h0, d[7:0]};
    if (c[1] && c[4]) w[8] = ^w[7:0] ^ c[0];
    if (c[1] && !c[4]) w[7] = ^w[6:0] ^ c[0];
    return w;
  endfunction

  // Samples each bit about mid way, 16 clocks apart
  task automatic send(input logic [8:0] d, w, input int nb);
    logic b;
    @(negedge clk);
    tx_data = d;
    tx_valid = 1'h1;
    wait_for(0);
    @(negedge clk);
    tx_valid = 1'h0;
    repeat (7) @(negedge clk);
    for (int i = 0; i <= nb + 1; i++) begin
      b = (i == 0) ? 1'h0 : (i > nb) ? 1'h1 : w[i-1];
      chk("txd_out", {8'h0, b}, {8'h0, txd_out});
      repeat (16) @(negedge clk);
    end
  endtask

  task automatic recv(input logic [8:0] w);
    wait_for(1);
    chk("rx_data", w, rx_data);
    chk("rx_errors", 9'h0, {7'h0, rx_parity_err, rx_frame_err});
    rx_ready = 1'h1;
    @(negedge clk);
    rx_ready = 1'h0;
  endtask

  task automatic s_regs;
    rd(8'h40, 8'h00);
    rd(8'h41, 8'h04);
    rd(8'h42, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'h40, 8'h05);
    rd(8'h40, 8'h00);
    wr(8'h41, 8'h10);
    rd(8'h40, 8'h05);
    rd(8'h41, 8'h10);
    wr(8'h42, 8'hff);
    rd(8'h42, 8'hb7);
  endtask

  task automatic s_gen;
    chk("baud_running", 9'h0, {8'h0, baud_running});
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h03);
    transmitter_on = 1'h1;
    wait_for(2);
    repeat (3) @(negedge clk);
    chk("baud_tick", 9'h1, {8'h0, baud_tick});
    repeat (2) @(negedge clk);
    chk("baud_tick", 9'h0, {8'h0, baud_tick});
    wr(8'h41, 8'h00);
    repeat (2) @(negedge clk);
    chk("baud_running", 9'h0, {8'h0, baud_running});
    wr(8'h41, 8'h01);
  endtask

  task automatic s_frames;
    logic [7:0] cf [6] = '{8'h00, 8'h30, 8'h82, 8'hb3, 8'h83, 8'h12};
    logic [8:0] dt [6] = '{9'h1a5, 9'h15a, 9'h0c3, 9'h17e, 9'h001, 9'h0ff};
    receiver_on = 1'h1;
    for (int k = 0; k < 6; k++) begin
      // Release the line before leaving internal loop back
      remote_low = 1'h0;
      // Let the pin filter see the high line before routing changes
      repeat (4) @(negedge clk);
      wr(8'h42, cf[k]);
      remote_low = cf[k][7] & ~cf[k][5];
      @(negedge clk);
      chk("rxd_pin_used", {8'h0, ~cf[k][7]}, {8'h0, rxd_pin_used});
      send(dt[k], frame(cf[k], dt[k]), cf[k][4] ? 9 : 8);
      recv(frame(cf[k], dt[k]));
    end
  endtask

  task automatic s_buf;
    for (int k = 0; k < 3; k++) begin
      send(frame(8'h12, 9'h0f0 + 9'(k)), frame(8'h12, 9'h0f0 + 9'(k)), 9);
    end
    repeat (40) @(negedge clk);
    chk("rx_overrun", 9'h1, {8'h0, ovr_seen});
    recv(frame(8'h12, 9'h0f0));
    recv(frame(8'h12, 9'h0f1));
    chk("rx_valid", 9'h0, {8'h0, rx_valid});
  endtask

  task automatic s_irq;
    for (int k = 0; k < 16; k++) begin
      if (k % 4 == 0) wr(8'h40, {k[3:2], 6'h00});
      {break_detect_flag, rx_edge_flag} = k[1:0];
      repeat (2) @(negedge clk);
      chk("irq_request", {8'h0, (k[3] & k[1]) | (k[2] & k[0])}, {8'h0, irq_request});
    end
    {break_detect_flag, rx_edge_flag} = 2'h0;
  endtask

  // One idle report per quiet line after a frame
  task automatic s_idle;
    int c0;
    repeat (200) @(negedge clk);
    c0 = idle_cnt;
    send(9'h0f0, 9'h0f0, 9);
    recv(9'h0f0);
    repeat (300) @(negedge clk);
    chk("idle_detected", 9'h1, 9'(idle_cnt - c0));
  endtask

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset_n = 1'h1;
    s_regs();
    s_gen();
    s_frames();
    s_buf();
    s_irq();
    s_idle();
    end_sim();
  end
endmodule
